/* src/lcd_cmd_core.sv */
// command decoder and display ram addressing of the dot-matrix lcd driver
`timescale 1ns/1ns
`include "lcd_cmd_regs.svh"
module lcd_cmd_core (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic host_valid,
    output logic host_ready,
    input wire logic cmd_data_select,
    input wire logic host_read,
    input wire logic [7:0] host_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    input wire logic serial_sel,
    input wire logic [5:0] scan_com,
    input wire logic [7:0] scan_col,
    output logic dot_out,
    output logic display_on,
    output logic reverse_mode,
    output logic all_dots_on,
    output logic power_save,
    output logic com_reverse,
    output logic [6:0] start_line,
    output logic indicator_common_output,
    output logic [4:0] page_addr,
    output logic [7:0] col_addr,
    output logic inc_page,
    output logic cmd_blocked
);
    logic ser_meta_q;
    logic ser_q;
    logic buf_valid;
    logic buf_ready;
    logic [9:0] buf_data;
    logic pop;
    logic pop_cmd;
    logic pop_wr;
    logic pop_rd;
    logic [7:0] pop_byte;
    logic [6:0] pop_lo7;
    logic [4:0] pop_lo5;
    lcd_cmd_pkg::mode_e mode_q;
    logic disp_on_q;
    logic rev_q;
    logic all_on_q;
    logic com_rev_q;
    logic [6:0] start_q;
    logic ind_q;
    logic [4:0] page_q;
    logic [7:0] col_q;
    logic inc_page_q;
    logic rd_valid_q;
    logic [7:0] rd_data_q;
    logic ld_pend_q;
    logic [7:0] latch_q;
    logic [7:0] host_rdata;
    logic [5:0] com_eff;
    logic [6:0] line_addr;
    logic [2:0] bit_sel_q;
    logic [7:0] scan_rdata;
    logic dot_q;

    // true when the byte matches a command code exactly
    function automatic logic is_code(input logic [7:0] b, input logic [7:0] code);
        is_code = (b == code);
    endfunction

    // next column with wrap after the last column
    function automatic logic [7:0] col_next(input logic [7:0] c);
        col_next = (c >= `COL_LAST) ? `RST_COL : c + 8'h01;
    endfunction

    // serial strap is a pin: two flops before use
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ser_meta_q <= 1'b0;
            ser_q <= 1'b0;
        end
        else if (ce)
        begin
            ser_meta_q <= serial_sel;
            ser_q <= ser_meta_q;
        end
    end

    // host bytes pass a two-entry buffer; a stalled reader backs up into host_ready
    lcd_pair_fifo #(.W(10)) u_in_buf (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(host_valid),
        .in_ready(host_ready),
        .in_data({host_read, cmd_data_select, host_data}),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // a pending read answer holds the decoder so answers never overlap
    assign buf_ready = !rd_valid_q && !ld_pend_q;
    assign pop = ce && buf_valid && buf_ready;
    assign pop_byte = buf_data[7:0];
    assign pop_lo7 = pop_byte[6:0];
    assign pop_lo5 = pop_byte[4:0];
    assign pop_cmd = pop && !buf_data[8] && !buf_data[9];
    assign pop_wr = pop && buf_data[8] && !buf_data[9];
    assign pop_rd = pop && buf_data[8] && buf_data[9];

    // entry modes for the two-byte settings; only a command byte ends them
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            mode_q <= lcd_cmd_pkg::MODE_IDLE;
        else if (pop_cmd)
        begin
            unique case (mode_q)
                lcd_cmd_pkg::MODE_IDLE:
                begin
                    if (is_code(pop_byte, `CMD_START_MODE))
                        mode_q <= lcd_cmd_pkg::MODE_START;
                    else if (is_code(pop_byte, `CMD_PAGE_MODE))
                        mode_q <= lcd_cmd_pkg::MODE_PAGE;
                end
                lcd_cmd_pkg::MODE_START: mode_q <= lcd_cmd_pkg::MODE_IDLE;
                lcd_cmd_pkg::MODE_PAGE: mode_q <= lcd_cmd_pkg::MODE_IDLE;
                default: mode_q <= lcd_cmd_pkg::MODE_IDLE;
            endcase
        end
    end

    // one-byte display controls, decoded only outside the entry modes
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            disp_on_q <= 1'b0;
            rev_q <= 1'b0;
            all_on_q <= 1'b0;
            com_rev_q <= 1'b0;
            inc_page_q <= 1'b0;
        end
        else if (pop_cmd && mode_q == lcd_cmd_pkg::MODE_IDLE)
        begin
            unique case (pop_byte)
                `CMD_DISP_OFF, `CMD_DISP_ON: disp_on_q <= pop_byte[0];
                `CMD_FORWARD, `CMD_REVERSE: rev_q <= pop_byte[0];
                `CMD_ALL_OFF, `CMD_ALL_ON: all_on_q <= pop_byte[0];
                `CMD_COM_FWD, `CMD_COM_REV: com_rev_q <= pop_byte[0];
                `CMD_DIR_COL, `CMD_DIR_PAGE: inc_page_q <= pop_byte[0];
                default: ;
            endcase
        end
    end

    // start line value byte: bit seven for the indicator, the rest for the line
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            start_q <= `RST_START_LINE;
            ind_q <= 1'b0;
        end
        else if (pop_cmd && mode_q == lcd_cmd_pkg::MODE_START)
        begin
            start_q <= pop_lo7;
            ind_q <= pop_byte[7];
        end
    end

    // page and column pointer: set by commands, advanced by data access
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            page_q <= `RST_PAGE;
            col_q <= `RST_COL;
        end
        else if (pop_cmd && mode_q == lcd_cmd_pkg::MODE_PAGE)
            page_q <= pop_lo5;
        else if (pop_cmd && mode_q == lcd_cmd_pkg::MODE_IDLE)
        begin
            if (pop_byte[7:4] == `CMD_COL_HI_TAG)
                col_q[7:4] <= pop_byte[3:0];
            else if (pop_byte[7:4] == `CMD_COL_LO_TAG)
                col_q[3:0] <= pop_byte[3:0];
        end
        else if (pop_wr)
        begin
            if (inc_page_q)
                page_q <= (page_q >= `PAGE_LAST) ? `RST_PAGE : page_q + 5'h01;
            else
                col_q <= col_next(col_q);
        end
        else if (pop_rd && !ser_q)
            col_q <= col_next(col_q);
    end

    // reads hand back the latch and refill it from ram, so the first is stale
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q <= `RST_BYTE;
            ld_pend_q <= 1'b0;
            latch_q <= `RST_BYTE;
        end
        else if (ce)
        begin
            if (pop_rd && !ser_q)
            begin
                rd_valid_q <= 1'b1;
                rd_data_q <= latch_q;
            end
            else if (rd_ready)
                rd_valid_q <= 1'b0;
            ld_pend_q <= pop_rd && !ser_q;
            if (ld_pend_q)
                latch_q <= host_rdata;
        end
    end

    // scan address: reverse scan mirrors the common, start line shifts the image
    assign com_eff = com_rev_q ? (`COM_LAST - scan_com) : scan_com;
    assign line_addr = start_q + {1'b0, com_eff};

    lcd_disp_ram u_ram (
        .core_clk(core_clk),
        .ce(ce),
        .we(pop_wr),
        .host_page(page_q),
        .host_col(col_q),
        .wdata(pop_byte),
        .host_re(pop_rd && !ser_q),
        .host_rdata(host_rdata),
        .scan_page({1'b0, line_addr[6:3]}),
        .scan_col(scan_col),
        .scan_rdata(scan_rdata)
    );

    // dot pipeline; power save blanks too since it implies display off
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bit_sel_q <= 3'h0;
            dot_q <= 1'b0;
        end
        else if (ce)
        begin
            bit_sel_q <= line_addr[2:0];
            dot_q <= disp_on_q && (all_on_q || (scan_rdata[bit_sel_q] ^ rev_q));
        end
    end

    assign power_save = all_on_q && !disp_on_q;
    assign dot_out = dot_q;
    assign display_on = disp_on_q;
    assign reverse_mode = rev_q;
    assign all_dots_on = all_on_q;
    assign com_reverse = com_rev_q;
    assign start_line = start_q;
    assign indicator_common_output = ind_q;
    assign page_addr = page_q;
    assign col_addr = col_q;
    assign inc_page = inc_page_q;
    assign cmd_blocked = (mode_q != lcd_cmd_pkg::MODE_IDLE);
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_disp_on_cmd: assert property (
        pop_cmd && !cmd_blocked && pop_byte == `CMD_DISP_ON |=> display_on)
    else $error("display on command did not enable panel");
    a_disp_off_cmd: assert property (
        pop_cmd && !cmd_blocked && pop_byte == `CMD_DISP_OFF |=> !display_on)
    else $error("display off command did not blank panel");
    a_reverse_sel: assert property (
        pop_cmd && !cmd_blocked && pop_byte[7:1] == 7'h53 |=> reverse_mode == $past(pop_byte[0]))
    else $error("reverse mode not taken from bit zero");
    a_blank_when_off: assert property (
        !display_on && ce ##1 !display_on && ce |=> !dot_out)
    else $error("dot lit while display off");
    a_com_dir_sel: assert property (
        pop_cmd && !cmd_blocked && pop_byte == `CMD_COM_REV |=> com_reverse)
    else $error("reverse common scan not selected");
    a_start_value: assert property (
        pop_cmd && mode_q == lcd_cmd_pkg::MODE_START |=> start_line == $past(pop_lo7) && !cmd_blocked)
    else $error("start line value not stored or mode kept");
    a_start_block: assert property (
        pop_cmd && mode_q == lcd_cmd_pkg::MODE_START |=> display_on == $past(display_on))
    else $error("command executed during start line entry");
    a_indicator_bit: assert property (
        pop_cmd && mode_q == lcd_cmd_pkg::MODE_START |=> indicator_common_output == $past(pop_byte[7]))
    else $error("indicator data not from bit seven");
    a_page_value: assert property (
        pop_cmd && mode_q == lcd_cmd_pkg::MODE_PAGE |=> page_addr == $past(pop_lo5) && !cmd_blocked)
    else $error("page value not stored or mode kept");
    a_write_col_inc: assert property (
        pop_wr && !inc_page && col_addr < `COL_LAST |=> col_addr == $past(col_addr) + 8'h01)
    else $error("column not advanced after write");
    a_read_answer: assert property (
        pop_rd && !ser_q |=> rd_valid && col_addr == $past(col_next(col_addr)))
    else $error("read not answered or column not advanced");
    a_serial_noread: assert property (
        pop_rd && ser_q |=> !rd_valid)
    else $error("read answered on serial interface");

    c_start_seq: cover property (pop_cmd && mode_q == lcd_cmd_pkg::MODE_START);
    c_page_seq: cover property (pop_cmd && mode_q == lcd_cmd_pkg::MODE_PAGE);
    c_read_stall: cover property (rd_valid && !rd_ready && !host_ready);
    c_dot_lit: cover property (dot_out);
endmodule

/* src/lcd_cmd_regs.svh */
// command codes, field positions, limits and reset values of the lcd command block
`ifndef LCD_CMD_REGS_SVH
`define LCD_CMD_REGS_SVH

`define CMD_DISP_OFF 8'hAE
`define CMD_DISP_ON 8'hAF
`define CMD_FORWARD 8'hA6
`define CMD_REVERSE 8'hA7
`define CMD_ALL_OFF 8'hA4
`define CMD_ALL_ON 8'hA5
`define CMD_COM_FWD 8'hC4
`define CMD_COM_REV 8'hC5
`define CMD_START_MODE 8'h8A
`define CMD_PAGE_MODE 8'hB0
`define CMD_DIR_COL 8'h84
`define CMD_DIR_PAGE 8'h85
`define CMD_NOP 8'hE3
`define CMD_COL_HI_TAG 4'h1
`define CMD_COL_LO_TAG 4'h0

`define COL_LAST 8'hB3
`define PAGE_LAST 5'h11
`define RAM_COLS 180
`define RAM_PAGES 18
`define RAM_WORDS 3240
`define COM_LAST 6'h3F

`define RST_START_LINE 7'h00
`define RST_PAGE 5'h00
`define RST_COL 8'h00
`define RST_BYTE 8'h00

`endif

/* src/lcd_cmd_pkg.sv */
// types shared by the lcd command block
package lcd_cmd_pkg;
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b001,
        MODE_START = 3'b010,
        MODE_PAGE = 3'b100
    } mode_e;
endpackage

/* src/lcd_pair_fifo.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module lcd_pair_fifo #(
    parameter int W = 10
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [0:1];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // full and empty come straight from the count, so no word slips past
    assign in_ready = ce && (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    // storage, written only on an accepted push
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= ~wr_ptr_q;
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // a stalled reader must find the same head word on the next cycle
    a_fifo_hold_stall: assert property (@(posedge core_clk) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer head word lost or changed while stalled");
endmodule

/* src/lcd_disp_ram.sv */
// display ram: one write port, a host read port and a scan read port
`timescale 1ns/1ns
`include "lcd_cmd_regs.svh"
module lcd_disp_ram (
    input wire logic core_clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [4:0] host_page,
    input wire logic [7:0] host_col,
    input wire logic [7:0] wdata,
    input wire logic host_re,
    output logic [7:0] host_rdata,
    input wire logic [4:0] scan_page,
    input wire logic [7:0] scan_col,
    output logic [7:0] scan_rdata
);
    logic [7:0] mem_q [0:`RAM_WORDS-1];

    // linear word index from page and column
    function automatic logic [11:0] word_idx(input logic [4:0] pg, input logic [7:0] col);
        logic [11:0] prod;
        prod = 12'(pg) * 12'(`RAM_COLS);
        word_idx = prod + 12'(col);
    endfunction

    // host side: write or registered read at the current address
    always_ff @(posedge core_clk)
    begin
        if (ce && we)
            mem_q[word_idx(host_page, host_col)] <= wdata;
        if (ce && host_re)
            host_rdata <= mem_q[word_idx(host_page, host_col)];
    end

    // scan side reads every cycle with ce high; the image never disturbs the host port
    always_ff @(posedge core_clk)
    begin
        if (ce)
            scan_rdata <= mem_q[word_idx(scan_page, scan_col)];
    end
endmodule

/* verif/lcd_host_model.sv */
// host side model: offers bytes in order and collects read answers
`timescale 1ns/1ns
module lcd_host_model (
    input wire logic core_clk,
    output logic host_valid,
    input wire logic host_ready,
    output logic cmd_data_select,
    output logic host_read,
    output logic [7:0] host_data,
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [7:0] rd_data
);
    logic [9:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic stall = 1'h0;
    initial
    begin
        host_valid = 1'h0;
        {cmd_data_select, host_read, host_data} = 10'h000;
        rd_ready = 1'h0;
    end
    // queue one byte as select, read flag and value
    task put(input logic [9:0] w);
        tx_q.push_back(w);
    endtask
    // a byte stands until taken; both bytes of a pair leave back to back
    always @(posedge core_clk)
    begin
        if (host_valid === 1'h1 && host_ready === 1'h1)
            void'(tx_q.pop_front());
        host_valid <= tx_q.size() > 0;
        if (tx_q.size() > 0)
            {cmd_data_select, host_read, host_data} <= tx_q[0];
        else
            host_data <= ~host_data; // released bus must not look stable
    end
    // answers taken at a random pace, or held off while stalling
    always @(posedge core_clk)
    begin
        if (rd_valid === 1'h1 && rd_ready === 1'h1)
            rx_q.push_back(rd_data);
        rd_ready <= !stall && $urandom_range(3) != 0;
    end
endmodule

/* verif/tb_top.sv */
// self-checking bench of the lcd command block against a queue model
`timescale 1ns/1ns
`include "lcd_cmd_regs.svh"
module tb_top;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic ce = 1'h1;
    logic serial_sel = 1'h0;
    logic [5:0] scan_com = 6'h00;
    logic [7:0] scan_col = 8'h00;
    logic host_valid, host_ready, cmd_data_select, host_read, rd_valid, rd_ready, dot_out;
    logic display_on, reverse_mode, all_dots_on, power_save, com_reverse, inc_page;
    logic indicator_common_output, cmd_blocked;
    logic [7:0] host_data, rd_data, col_addr;
    logic [6:0] start_line;
    logic [4:0] page_addr;
    int failures = 0;
    int cmp_count = 0;
    int m_on = 0, m_rev = 0, m_all = 0, m_crev = 0, m_start = 0, m_ind = 0, m_page = 0;
    int m_col = 0, m_incp = 0, m_mode = 0, m_latch = 0, m_dummy = 1, seed;
    int ram[int];
    int exp_q[$];
    int codes[14] = '{8'hAF, 8'hA7, 8'hE3, 8'hA5, 8'hC5, 8'h3C, 8'h85, 8'hA4, 8'hA6, 8'hC4,
        8'h84, 8'hAE, 8'hA5, 8'hA4};

    // core clock, 20 ns period
    always #10 core_clk = ~core_clk;

    lcd_cmd_core u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .host_valid(host_valid),
        .host_ready(host_ready), .cmd_data_select(cmd_data_select), .host_read(host_read),
        .host_data(host_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .serial_sel(serial_sel), .scan_com(scan_com), .scan_col(scan_col), .dot_out(dot_out),
        .display_on(display_on), .reverse_mode(reverse_mode), .all_dots_on(all_dots_on),
        .power_save(power_save), .com_reverse(com_reverse), .start_line(start_line),
        .indicator_common_output(indicator_common_output), .page_addr(page_addr),
        .col_addr(col_addr), .inc_page(inc_page), .cmd_blocked(cmd_blocked)
    );

    lcd_host_model u_host (
        .core_clk(core_clk), .host_valid(host_valid), .host_ready(host_ready),
        .cmd_data_select(cmd_data_select), .host_read(host_read), .host_data(host_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data)
    );

    // one comparison, reported at once when it differs
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // queue a byte and advance the model in the same order
    task send(input logic s, input logic r, input logic [7:0] d);
        int v, k;
        v = d;
        k = m_page * 256 + m_col;
        u_host.put({s, r, d});
        if (s && r && !serial_sel)
        begin
            exp_q.push_back(m_dummy ? -1 : m_latch);
            m_latch = ram.exists(k) ? ram[k] : -1;
            m_dummy = 0;
            m_col = (m_col + 1) % 180;
        end
        else if (s && !r)
        begin
            ram[k] = v;
            m_page = m_incp ? (m_page + 1) % 18 : m_page;
            m_col = m_incp ? m_col : (m_col + 1) % 180;
        end
        else if (!s && m_mode != 0)
        begin
            m_start = m_mode == 1 ? v % 128 : m_start;
            m_ind = m_mode == 1 ? v / 128 : m_ind;
            m_page = m_mode == 2 ? v % 32 : m_page;
            m_dummy = m_dummy | (m_mode == 2);
            m_mode = 0;
        end
        else if (!s && v < 32)
        begin
            m_col = v / 16 ? v % 16 * 16 + m_col % 16 : m_col - m_col % 16 + v;
            m_dummy = 1;
        end
        else if (!s)
            case (v)
                `CMD_DISP_OFF, `CMD_DISP_ON: m_on = v % 2;
                `CMD_FORWARD, `CMD_REVERSE: m_rev = v % 2;
                `CMD_ALL_OFF, `CMD_ALL_ON: m_all = v % 2;
                `CMD_COM_FWD, `CMD_COM_REV: m_crev = v % 2;
                `CMD_START_MODE: m_mode = 1;
                `CMD_PAGE_MODE: m_mode = 2;
                `CMD_DIR_COL, `CMD_DIR_PAGE: m_incp = v % 2;
                default: ;
            endcase
    endtask

    // let queued bytes pass the buffer and the decoder
    task wait_idle();
        for (int i = 0; i < 2000 && u_host.tx_q.size() > 0; i++)
            @(posedge core_clk);
        // a queue that never drains is a hang, counted as a mismatch
        if (u_host.tx_q.size() > 0)
            failures++;
        repeat (16) @(posedge core_clk);
        #1;
    endtask

    // every state output against the model
    task check_state();
        chk("display_on", {7'h00, display_on}, m_on[7:0]);
        chk("reverse_mode", {7'h00, reverse_mode}, m_rev[7:0]);
        chk("all_dots_on", {7'h00, all_dots_on}, m_all[7:0]);
        chk("power_save", {7'h00, power_save}, {7'h00, m_all[0] & ~m_on[0]});
        chk("com_reverse", {7'h00, com_reverse}, m_crev[7:0]);
        chk("start_line", {1'h0, start_line}, m_start[7:0]);
        chk("indicator", {7'h00, indicator_common_output}, m_ind[7:0]);
        chk("cmd_blocked", {7'h00, cmd_blocked}, {7'h00, m_mode != 0});
        chk("page_addr", {3'h0, page_addr}, m_page[7:0]);
        chk("col_addr", col_addr, m_col[7:0]);
        chk("inc_page", {7'h00, inc_page}, m_incp[7:0]);
    endtask

    // random scan points; inputs held long enough for the dot pipeline
    task scan_check(input int n);
        int line, k, b, e;
        repeat (n)
        begin
            @(posedge core_clk);
            scan_com <= 6'($urandom_range(63));
            scan_col <= 8'($urandom_range(7));
            repeat (3) @(posedge core_clk);
            #1;
            line = (m_start + (m_crev ? 63 - scan_com : scan_com)) % 128;
            k = line / 8 * 256 + scan_col;
            b = ram.exists(k) ? ram[k] >> (line % 8) & 1 : 0;
            e = m_on & (m_all | (b ^ m_rev));
            chk("dot_out", {7'h00, dot_out}, e[7:0]);
        end
    endtask

    // pair each collected answer with its expected byte
    task drain();
        int e;
        logic [7:0] s;
        while (exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            s = u_host.rx_q.size() > 0 ? u_host.rx_q.pop_front() : 8'hXX;
            if (e >= 0)
                chk("rd_data", s, e[7:0]);
        end
        chk("extra_answers", 8'(u_host.rx_q.size()), 8'h00);
    endtask

    // counts, verdict and end of run
    task give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial
    begin
        seed = $urandom(30974);
        repeat (3) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        #1;
        check_state();
        $display("test reset done");
        foreach (codes[i])
        begin
            send(1'h0, 1'h0, codes[i][7:0]);
            wait_idle();
            check_state();
        end
        $display("test commands done");
        send(1'h0, 1'h0, `CMD_START_MODE);
        wait_idle();
        check_state();
        send(1'h1, 1'h0, 8'h5A); // data still lands while waiting
        send(1'h0, 1'h0, `CMD_DISP_ON); // taken as the line value
        send(1'h0, 1'h0, `CMD_PAGE_MODE);
        wait_idle();
        check_state();
        send(1'h0, 1'h0, 8'hE5); // upper bits are ignored
        send(1'h0, 1'h0, 8'h1B);
        send(1'h0, 1'h0, 8'h03);
        send(1'h1, 1'h0, 8'hC3); // last column wraps
        wait_idle();
        check_state();
        $display("test entry_modes done");
        send(1'h0, 1'h0, `CMD_DIR_PAGE);
        for (int c = 0; c < 8; c++)
        begin
            send(1'h0, 1'h0, `CMD_PAGE_MODE);
            send(1'h0, 1'h0, 8'h00);
            send(1'h0, 1'h0, 8'h10);
            send(1'h0, 1'h0, 8'(c));
            repeat (16) send(1'h1, 1'h0, 8'($urandom));
        end
        for (int i = 0; i < 4; i++)
        begin
            send(1'h0, 1'h0, `CMD_START_MODE);
            send(1'h0, 1'h0, 8'($urandom));
            send(1'h0, 1'h0, `CMD_FORWARD | 8'(i % 2));
            send(1'h0, 1'h0, `CMD_COM_FWD | 8'(i / 2));
            send(1'h0, 1'h0, i == 3 ? `CMD_ALL_ON : `CMD_ALL_OFF);
            send(1'h0, 1'h0, i == 1 ? `CMD_DISP_OFF : `CMD_DISP_ON);
            wait_idle();
            check_state();
            scan_check(12);
        end
        $display("test scan done");
        send(1'h0, 1'h0, `CMD_DIR_COL);
        send(1'h0, 1'h0, `CMD_PAGE_MODE);
        send(1'h0, 1'h0, 8'h03);
        send(1'h0, 1'h0, 8'h10);
        send(1'h0, 1'h0, 8'h02);
        u_host.stall = 1'h1;
        repeat (7) send(1'h1, 1'h1, 8'h00);
        repeat (30) @(posedge core_clk);
        #1;
        chk("host_ready", {7'h00, host_ready}, 8'h00);
        u_host.stall = 1'h0;
        wait_idle();
        drain();
        check_state();
        $display("test reads done");
        @(posedge core_clk);
        serial_sel <= 1'h1;
        repeat (4) @(posedge core_clk);
        send(1'h1, 1'h1, 8'h00);
        wait_idle();
        drain();
        check_state();
        $display("test serial done");
        // clock enable low: the buffer refuses and the display state holds
        @(posedge core_clk);
        ce <= 1'h0;
        send(1'h0, 1'h0, `CMD_DISP_OFF);
        repeat (6) @(posedge core_clk);
        #1;
        chk("host_ready_frozen", {7'h00, host_ready}, 8'h00);
        chk("display_frozen", {7'h00, display_on}, {7'h00, ~m_on[0]});
        @(posedge core_clk);
        ce <= 1'h1;
        wait_idle();
        check_state();
        $display("test clock_enable done");
        give_verdict();
    end

    // hang guard, far beyond the expected run
    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        give_verdict();
    end
endmodule
